// *** common/mem_arb_params.svh ***
`ifndef MEM_ARB_PARAMS_SVH
`define MEM_ARB_PARAMS_SVH

// Grant and reset timing: clock counts, a counter load value and periods in ns.
`define CLK_PERIOD_NS      50
`define DRAIN_CLOCKS       5
`define DRAIN_LOAD         3'h3
`define HW_RESET_TX_CLOCKS 10
`define TX_CLK_PERIOD_NS   100

// Values loaded by a hardware reset; CMD_SOFT_TIMER is loaded by a software reset while the timer-run bit is set.
`define CMD_HW_RESET       16'h0094
`define CMD_SOFT_TIMER     16'h00a4
`define IMR_RESET          16'h0000
`define ISR_RESET          16'h0000
`define TCR_RESET          16'h0101
`define END_BUFFER_WORD_COUNT_RESET         16'h02f8
`define SEQ_RESET          16'h0000
`define CAM_EN_RESET       16'h0000

// Field positions.
`define CMD_SOFT_RST_BIT   7
`define CMD_TIMER_RUN_BIT  5
`define RCR_BCAST_BIT      13
`define RCR_LOOP_HI_BIT    10
`define RCR_LOOP_LO_BIT    9
`define DCR_RETRY_BIT      15
`define DCR_EXT_BUS_BIT    13
`define DATA_CONFIG_REG_SECOND_CLR_MSB       4

`endif

// *** common/mem_arb_pkg.sv ***
`default_nettype none

package mem_arb_pkg;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_DRAIN = 4'b0010,
    ST_MEM   = 4'b0100,
    ST_REG   = 4'b1000
  } arb_state_t;

  typedef enum logic [3:0] {
    SEL_CMD, SEL_IMR, SEL_ISR, SEL_TCR, SEL_RCR,
    SEL_END_BUFFER_WORD_COUNT, SEL_SEQ, SEL_CAM_EN, SEL_DCR, SEL_DATA_CONFIG_REG_SECOND
  } reg_sel_t;

endpackage

`default_nettype wire

// *** src/shared_memory_arbiter_and_reset.sv ***
// Behaviour
// R1: Host claims memory by asserting request, holds it, releases by deasserting it.
// R2: Device grants memory with acknowledge; host then uses memory until it withdraws.
// R3: Request passes through a two-stage synchroniser before use.
// R4: Acknowledge one clock after sampling when idle, five when mastering the bus.
// R5: Each master wait state adds one clock to the five-clock grant delay.
// R6: Acknowledge drops within one clock of request release; master work resumes.
// R7: Memory acknowledge stays asserted continuously until the request is withdrawn.
// R8: Chip select follows same grant, enters slave cycle, needs active address strobe.
// R9: Chip-select acknowledge holds only while the address strobe stays active.
// R10: Host never asserts chip select and request together; two clocks apart.
// R11: Two resets exist: hardware pin and software command bit, with different effects.
// R12: Hardware reset held at least ten transmit or bus clocks, whichever longer.
// R13: Hardware reset disables rx/tx, halts timer, masks and clears interrupts.
// R14: Hardware reset leaves transmit control at 0101h.
// R15: Hardware reset loads end-buffer count 02F8h and clears sequence counters.
// R16: Hardware reset clears table enables, loopback and broadcast bits only.
// R17: Hardware reset clears first config bits 15,13 and second config bits 4..0.
// R18: Those cleared bits select the documented default bus and compare behaviour.
// R19: Command reads 0094h after hardware reset, 0094h or 00A4h after software.
// R20: Software reset stops DMA and interrupts, leaving registers accessible.
// R21: During hardware reset acknowledge stays off, request and chip select ignored.
`timescale 1ns/1ns
`default_nettype none
`include "mem_arb_params.svh"

module shared_memory_arbiter_and_reset (
  input  wire logic                    mclk,
  input  wire logic                    sys_rst,
  input  wire logic                    shared_mem_request_n,
  input  wire logic                    chip_select_n,
  input  wire logic                    slave_addr_strobe_n,
  input  wire logic                    bus_style_select,
  input  wire logic                    dma_active,
  input  wire logic                    dma_wait,
  output logic                         dma_pause,
  output logic                         dma_halt,
  output logic                         irq_enable,
  output logic                         slave_cycle,
  output logic                         slave_mem_ack_n,
  input  wire logic                    soft_reset_set,
  input  wire logic                    reg_wr_en,
  input  wire mem_arb_pkg::reg_sel_t   reg_wr_sel,
  input  wire logic [15:0]             reg_wr_data,
  input  wire logic [15:0]             isr_event,
  output logic [15:0]                  cmd_reg,
  output logic [15:0]                  imr_reg,
  output logic [15:0]                  isr_reg,
  output logic [15:0]                  tcr_reg,
  output logic [15:0]                  rcr_reg,
  output logic [15:0]                  end_buffer_word_count_reg,
  output logic [15:0]                  seq_reg,
  output logic [15:0]                  cam_en_reg,
  output logic [15:0]                  dcr_reg,
  output logic [15:0]                  data_config_reg_second_reg
);
  import mem_arb_pkg::*;

  // Strobe polarity differs between the two bus styles.
  function automatic logic strobe_active(input logic sas_n, input logic style);
    strobe_active = style ? !sas_n : sas_n;
  endfunction

  function automatic logic wr_hit(input logic en, input reg_sel_t sel, input reg_sel_t me);
    wr_hit = en && (sel == me);
  endfunction

  // ----------------------------------------------------------------
  // Request synchronisers
  // ----------------------------------------------------------------
  logic       req_meta_reg;
  logic       req_s2_reg;
  logic       cs_meta_reg;
  logic       cs_s2_reg;
  logic       strobe_act;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      req_meta_reg <= 1'b0; // [R21]
      req_s2_reg   <= 1'b0;
      cs_meta_reg  <= 1'b0;
      cs_s2_reg    <= 1'b0;
    end else begin
      req_meta_reg <= !shared_mem_request_n; // [R3]
      req_s2_reg   <= req_meta_reg;
      cs_meta_reg  <= !chip_select_n;
      cs_s2_reg    <= cs_meta_reg;
    end
  end

  assign strobe_act = strobe_active(slave_addr_strobe_n, bus_style_select);

  // ----------------------------------------------------------------
  // Arbiter state machine
  // ----------------------------------------------------------------
  arb_state_t state_reg;
  arb_state_t state_next;
  logic [2:0] drain_cnt_reg;
  logic       drain_to_reg_reg;
  logic       ack_reg;
  logic       ack_next;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (req_s2_reg || (cs_s2_reg && strobe_act)) begin // [R8]
          state_next = dma_active ? ST_DRAIN : (req_s2_reg ? ST_MEM : ST_REG); // [R4]
        end
      end
      ST_DRAIN: begin
        if (!req_s2_reg && !cs_s2_reg) begin
          state_next = ST_IDLE;
        end else if (!dma_wait && drain_cnt_reg == 3'h0) begin // [R5]
          state_next = drain_to_reg_reg ? ST_REG : ST_MEM;
        end
      end
      ST_MEM: begin
        if (!req_s2_reg) begin
          state_next = ST_IDLE; // [R6]
        end
      end
      ST_REG: begin
        if (!cs_s2_reg) begin
          state_next = ST_IDLE;
        end
      end
      default: state_next = ST_IDLE;
    endcase
  end

  // Memory grant holds while requested; register grant follows the strobe.
  assign ack_next = (state_next == ST_MEM) ||
                    (state_next == ST_REG && cs_s2_reg && strobe_act); // [R2] [R7] [R9]

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state_reg <= ST_IDLE; // [R21]
      ack_reg   <= 1'b0;
    end else begin
      state_reg <= state_next;
      ack_reg   <= ack_next;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      drain_cnt_reg    <= 3'h0;
      drain_to_reg_reg <= 1'b0;
    end else if (state_reg == ST_IDLE) begin
      drain_cnt_reg    <= `DRAIN_LOAD; // [R4]
      drain_to_reg_reg <= !req_s2_reg;
    end else if (state_reg == ST_DRAIN && !dma_wait && drain_cnt_reg != 3'h0) begin
      drain_cnt_reg    <= drain_cnt_reg - 3'h1; // [R5]
    end
  end

  assign slave_mem_ack_n = !ack_reg;
  assign slave_cycle     = (state_reg == ST_REG);
  // Master work stays suspended until the grant is released.
  assign dma_pause       = (state_reg != ST_IDLE) && (state_reg != ST_DRAIN); // [R6]

  // ----------------------------------------------------------------
  // Command register and software reset
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      cmd_reg <= `CMD_HW_RESET; // [R11] [R13] [R19]
    end else if (soft_reset_set) begin
      cmd_reg <= cmd_reg[`CMD_TIMER_RUN_BIT] ? `CMD_SOFT_TIMER : `CMD_HW_RESET; // [R11] [R19]
    end else if (wr_hit(reg_wr_en, reg_wr_sel, SEL_CMD)) begin
      cmd_reg <= reg_wr_data;
    end
  end

  assign dma_halt   = cmd_reg[`CMD_SOFT_RST_BIT];  // [R20]
  assign irq_enable = !cmd_reg[`CMD_SOFT_RST_BIT]; // [R20]

  // ----------------------------------------------------------------
  // Interrupt, transmit and buffer registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      imr_reg <= `IMR_RESET; // [R13]
    end else if (wr_hit(reg_wr_en, reg_wr_sel, SEL_IMR)) begin
      imr_reg <= reg_wr_data;
    end
  end

  // Status bits clear on a written one; a new event wins over the clear unless dma_halt is set, when events are dropped.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      isr_reg <= `ISR_RESET; // [R13]
    end else if (wr_hit(reg_wr_en, reg_wr_sel, SEL_ISR)) begin
      isr_reg <= (isr_reg & ~reg_wr_data) | (dma_halt ? 16'h0000 : isr_event);
    end else if (!dma_halt) begin
      isr_reg <= isr_reg | isr_event; // [R20]
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      tcr_reg <= `TCR_RESET; // [R14]
    end else if (wr_hit(reg_wr_en, reg_wr_sel, SEL_TCR)) begin
      tcr_reg <= reg_wr_data;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      end_buffer_word_count_reg <= `END_BUFFER_WORD_COUNT_RESET; // [R15]
    end else if (wr_hit(reg_wr_en, reg_wr_sel, SEL_END_BUFFER_WORD_COUNT)) begin
      end_buffer_word_count_reg <= reg_wr_data;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      seq_reg <= `SEQ_RESET; // [R15]
    end else if (wr_hit(reg_wr_en, reg_wr_sel, SEL_SEQ)) begin
      seq_reg <= reg_wr_data;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      cam_en_reg <= `CAM_EN_RESET; // [R16]
    end else if (wr_hit(reg_wr_en, reg_wr_sel, SEL_CAM_EN)) begin
      cam_en_reg <= reg_wr_data;
    end
  end

  // ----------------------------------------------------------------
  // Partially reset configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rcr_reg[`RCR_BCAST_BIT]   <= 1'b0; // [R16]
      rcr_reg[`RCR_LOOP_HI_BIT] <= 1'b0;
      rcr_reg[`RCR_LOOP_LO_BIT] <= 1'b0;
    end else if (wr_hit(reg_wr_en, reg_wr_sel, SEL_RCR)) begin
      rcr_reg <= reg_wr_data;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      dcr_reg[`DCR_RETRY_BIT]   <= 1'b0; // [R17] [R18]
      dcr_reg[`DCR_EXT_BUS_BIT] <= 1'b0;
    end else if (wr_hit(reg_wr_en, reg_wr_sel, SEL_DCR)) begin
      dcr_reg <= reg_wr_data;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      data_config_reg_second_reg[`DATA_CONFIG_REG_SECOND_CLR_MSB:0] <= 5'h00; // [R17] [R18]
    end else if (wr_hit(reg_wr_en, reg_wr_sel, SEL_DATA_CONFIG_REG_SECOND)) begin
      data_config_reg_second_reg <= reg_wr_data;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_ack_reset_off: assert property (@(posedge mclk) // [R21]
    sys_rst |=> !ack_reg && state_reg == ST_IDLE)
    else $error("acknowledge not cleared by hardware reset");

  a_fast_grant_one: assert property (@(posedge mclk) disable iff (sys_rst) // [R4]
    (state_reg == ST_IDLE && req_s2_reg && !dma_active) |=> ack_reg)
    else $error("idle grant not one clock after sampled request");

  a_drain_min_five: assert property (@(posedge mclk) disable iff (sys_rst) // [R4]
    (state_reg == ST_IDLE && req_s2_reg && dma_active) |=> !ack_reg [*4])
    else $error("master grant came before five clocks");

  a_drain_wait_hold: assert property (@(posedge mclk) disable iff (sys_rst) // [R5]
    (state_reg == ST_DRAIN && dma_wait && (req_s2_reg || cs_s2_reg))
      |=> state_reg == ST_DRAIN && $stable(drain_cnt_reg))
    else $error("wait state did not lengthen grant delay");

  a_mem_ack_hold: assert property (@(posedge mclk) disable iff (sys_rst) // [R7]
    (ack_reg && state_reg == ST_MEM && req_s2_reg) |=> ack_reg)
    else $error("memory acknowledge dropped while requested");

  a_mem_ack_release: assert property (@(posedge mclk) disable iff (sys_rst) // [R6]
    (state_reg == ST_MEM && !req_s2_reg) |=> !ack_reg && !dma_pause)
    else $error("acknowledge not released within one clock");

  a_reg_ack_strobe: assert property (@(posedge mclk) disable iff (sys_rst) // [R9]
    ack_reg && state_reg == ST_REG |-> $past(strobe_act) && $past(cs_s2_reg))
    else $error("register acknowledge without active strobe");

  a_hw_reset_vals: assert property (@(posedge mclk) // [R13] [R14] [R15]
    sys_rst |=> cmd_reg == `CMD_HW_RESET && imr_reg == `IMR_RESET &&
      isr_reg == `ISR_RESET && tcr_reg == `TCR_RESET && end_buffer_word_count_reg == `END_BUFFER_WORD_COUNT_RESET)
    else $error("hardware reset register values wrong");

  a_hw_reset_clear: assert property (@(posedge mclk) // [R16] [R17]
    sys_rst |=> seq_reg == `SEQ_RESET && cam_en_reg == `CAM_EN_RESET &&
      !rcr_reg[`RCR_BCAST_BIT] && !dcr_reg[`DCR_RETRY_BIT] && data_config_reg_second_reg[4:0] == 5'h00)
    else $error("hardware reset did not clear fields");

  a_soft_reset_cmd: assert property (@(posedge mclk) disable iff (sys_rst) // [R19]
    soft_reset_set |=> (cmd_reg == `CMD_HW_RESET || cmd_reg == `CMD_SOFT_TIMER) && dma_halt)
    else $error("software reset command value wrong");

  a_soft_halt_irq: assert property (@(posedge mclk) disable iff (sys_rst) // [R20]
    dma_halt && !wr_hit(reg_wr_en, reg_wr_sel, SEL_ISR) |=> $stable(isr_reg) || !dma_halt)
    else $error("interrupt status changed while halted");

endmodule // shared_memory_arbiter_and_reset

`default_nettype wire

// *** tb/host_model.sv ***
`timescale 1ns/1ns
`default_nettype none

module host_model (
  input  wire logic mclk,
  input  wire logic bus_style,
  input  wire logic ack_n,
  output logic      req_n,
  output logic      cs_n,
  output logic      strobe_n
);
  initial begin
    req_n    = 1'b1;
    cs_n     = 1'b1;
    strobe_n = 1'b1;
  end

  // ----------------------------------------
  // Memory claim: lat and rel count bus clocks.
  // ----------------------------------------
  task automatic mem(input int hold, output int lat, output int drop, output int rel);
    req_n = 1'b0;
    lat   = 0;
    drop  = 0;
    rel   = 0;
    while (ack_n !== 1'b0 && lat < 30) begin
      @(negedge mclk);
      lat++;
    end
    repeat (hold) begin
      @(negedge mclk);
      if (ack_n !== 1'b0) drop++;
    end
    req_n = 1'b1;
    while (ack_n !== 1'b1 && rel < 30) begin
      @(negedge mclk);
      rel++;
    end
    repeat (2) @(negedge mclk);
  endtask

  // ----------------------------------------
  // One register access; chip select stays low afterwards.
  // ----------------------------------------
  task automatic reg_acc(output int lat, output int rel);
    cs_n     = 1'b0;
    strobe_n = !bus_style;
    lat      = 0;
    rel      = 0;
    while (ack_n !== 1'b0 && lat < 30) begin
      @(negedge mclk);
      lat++;
    end
    strobe_n = bus_style;
    while (ack_n !== 1'b1 && rel < 30) begin
      @(negedge mclk);
      rel++;
    end
    @(negedge mclk);
  endtask

  // Chip select off and strobe at its inactive level for the given bus style.
  task automatic idle(input logic style);
    cs_n     = 1'b1;
    strobe_n = style;
  endtask

  task automatic set_req(input logic on);
    req_n = !on;
  endtask
endmodule // host_model

`default_nettype wire

// *** tb/tb.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "mem_arb_params.svh"
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin err_total++; $display("mismatch at %0t: got %h expected %h", $time, a, b); end end

module tb;
  import mem_arb_pkg::*;
  logic mclk = 1'b0, sys_rst = 1'b1, bus_style_select = 1'b1, dma_active = 1'b0;
  logic dma_wait = 1'b0, soft_reset_set = 1'b0, reg_wr_en = 1'b0;
  logic dma_pause, dma_halt, irq_enable, slave_cycle, ack_n, req_n, cs_n, strobe_n;
  reg_sel_t    reg_wr_sel = SEL_CMD;
  logic [15:0] reg_wr_data = 16'h0000;
  logic [15:0] isr_event   = 16'h0000;
  logic [15:0] cmd, imr, isr, tcr, rcr, end_buffer_word_count, seq, address_match_table, data_config_reg, data_config_reg_second;
  int          err_total = 0, check_count = 0, lat, drop, rel;

  always #25 mclk = ~mclk;

  shared_memory_arbiter_and_reset DUT (
    .mclk(mclk), .sys_rst(sys_rst), .shared_mem_request_n(req_n), .chip_select_n(cs_n),
    .slave_addr_strobe_n(strobe_n), .bus_style_select(bus_style_select),
    .dma_active(dma_active), .dma_wait(dma_wait), .dma_pause(dma_pause), .dma_halt(dma_halt),
    .irq_enable(irq_enable), .slave_cycle(slave_cycle), .slave_mem_ack_n(ack_n),
    .soft_reset_set(soft_reset_set), .reg_wr_en(reg_wr_en), .reg_wr_sel(reg_wr_sel),
    .reg_wr_data(reg_wr_data), .isr_event(isr_event), .cmd_reg(cmd), .imr_reg(imr),
    .isr_reg(isr), .tcr_reg(tcr), .rcr_reg(rcr), .end_buffer_word_count_reg(end_buffer_word_count), .seq_reg(seq),
    .cam_en_reg(address_match_table), .dcr_reg(data_config_reg), .data_config_reg_second_reg(data_config_reg_second)
  );

  host_model host (
    .mclk(mclk), .bus_style(bus_style_select), .ack_n(ack_n),
    .req_n(req_n), .cs_n(cs_n), .strobe_n(strobe_n)
  );

  // ----------------------------------------
  // Access tasks, all entered at a falling edge.
  // ----------------------------------------
  task automatic wr(input reg_sel_t s, input logic [15:0] d);
    reg_wr_en   = 1'b1;
    reg_wr_sel  = s;
    reg_wr_data = d;
    @(negedge mclk);
    reg_wr_en = 1'b0;
    @(negedge mclk);
  endtask

  task automatic check_hw_values();
    `CHK(cmd, 16'h0094)
    `CHK({imr, isr}, 32'h0)
    `CHK(tcr, 16'h0101)
    `CHK({end_buffer_word_count, seq}, {16'h02f8, 16'h0000})
    `CHK({address_match_table, rcr[13], rcr[10:9]}, 19'h0)
    `CHK({data_config_reg[15], data_config_reg[13], data_config_reg_second[4:0]}, 7'h00)
  endtask

  task automatic final_report();
    $display("tests done: %0d checks, %0d mismatches", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    #(50 * 3000);
    err_total++;
    final_report();
  end

  initial begin
    repeat (6) @(negedge mclk);
    sys_rst = 1'b0;
    @(negedge mclk);
    check_hw_values();
    $display("test reset values done");
    fork
      host.mem(5, lat, drop, rel);
      begin
        repeat (4) @(negedge mclk);
        `CHK({dma_pause, slave_cycle}, 2'b10)
      end
    join
    `CHK({lat, drop, rel}, {32'd3, 32'd0, 32'd3})
    dma_active = 1'b1;
    host.mem(4, lat, drop, rel);
    `CHK({lat, drop}, {32'd7, 32'd0})
    fork
      host.mem(3, lat, drop, rel);
      begin
        repeat (4) @(negedge mclk);
        dma_wait = 1'b1;
        repeat (2) @(negedge mclk);
        dma_wait = 1'b0;
      end
    join
    `CHK(lat, 9)
    `CHK(dma_pause, 1'b0)
    dma_active = 1'b0;
    $display("test memory grant done");
    for (int st = 0; st < 2; st++) begin
      bus_style_select = st[0];
      host.idle(st[0]);
      @(negedge mclk);
      for (int n = 0; n < 2; n++) begin
        host.reg_acc(lat, rel);
        `CHK({lat, rel, slave_cycle}, {(n ? 32'd1 : 32'd3), 32'd1, 1'b1})
      end
      host.idle(st[0]);
      repeat (3) @(negedge mclk);
      `CHK(slave_cycle, 1'b0)
    end
    $display("test register grant done");
    wr(SEL_RCR, 16'hffff);
    wr(SEL_DCR, 16'hffff);
    wr(SEL_DATA_CONFIG_REG_SECOND, 16'hffff);
    wr(SEL_IMR, 16'h1234);
    wr(SEL_CAM_EN, 16'hffff);
    wr(SEL_TCR, 16'h0000);
    wr(SEL_CMD, 16'h0000);
    isr_event = 16'h0011;
    @(negedge mclk);
    isr_event = 16'h0000;
    `CHK(isr, 16'h0011)
    sys_rst = 1'b1;
    host.set_req(1'b1);
    repeat (`HW_RESET_TX_CLOCKS * `TX_CLK_PERIOD_NS / `CLK_PERIOD_NS) @(negedge mclk);
    `CHK(ack_n, 1'b1)
    host.set_req(1'b0);
    sys_rst = 1'b0;
    repeat (3) @(negedge mclk);
    check_hw_values();
    `CHK({rcr, data_config_reg, data_config_reg_second[11:0]}, {16'hd9ff, 16'h5fff, 12'hfe0})
    $display("test second reset done");
    for (int t = 0; t < 2; t++) begin
      wr(SEL_IMR, 16'h00f0);
      wr(SEL_CMD, t ? 16'h0020 : 16'h0000);
      soft_reset_set = 1'b1;
      @(negedge mclk);
      soft_reset_set = 1'b0;
      @(negedge mclk);
      `CHK(cmd, t ? 16'h00a4 : 16'h0094)
      `CHK({dma_halt, irq_enable, imr}, {2'b10, 16'h00f0})
    end
    isr_event = 16'hffff;
    @(negedge mclk);
    isr_event = 16'h0000;
    `CHK(isr, 16'h0000)
    $display("test soft reset done");
    final_report();
  end
endmodule // tb

`default_nettype wire
